// ---- bench/nested_priority_interrupt_controller_tb.sv ----
`timescale 1ns/1ps
module nested_priority_interrupt_controller_tb;
  logic                 clk_sys;
  logic                 rstn;
  logic                 ce;
  logic [2:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [15:0]          ext_pins;
  logic [13:0]          periph_flag;
  logic [13:0]          periph_en;
  logic [13:0]          periph_clr;
  nic_pkg::nic_instr_t  cpu_instr;
  logic                 irq_ack;
  nic_pkg::nic_sel_t    irq_sel;
  nic_pkg::nic_sel_t    last_sel;
  logic [7:0]           cc_out;
  logic                 level_masked;
  logic                 cpu_sleep;
  logic                 cpu_wake;
  int                   n_ack;
  int                   err_total;
  int                   n_tests;

  nic_ctrl u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_pins(ext_pins),
    .periph_flag(periph_flag), .periph_en(periph_en), .periph_clr(periph_clr),
    .cpu_instr(cpu_instr), .irq_ack(irq_ack), .irq_sel(irq_sel), .cc_out(cc_out),
    .level_masked(level_masked), .cpu_sleep(cpu_sleep), .cpu_wake(cpu_wake));

  nic_cpu_model u_cpu (.clk_sys(clk_sys), .rstn(rstn), .irq_sel(irq_sel),
    .irq_ack(irq_ack), .n_ack(n_ack), .last_sel(last_sel));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_of_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // Waitrequest read just after the edge is its value at that edge
  task bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i >= 20) begin
      err_total++;
      end_of_test();
    end
  endtask

  task ins(input nic_pkg::nic_cmd_t c, input logic [7:0] v);
    @(posedge clk_sys);
    cpu_instr <= '{cmd: c, cc: v};
    @(posedge clk_sys);
    cpu_instr <= '{cmd: nic_pkg::NIC_CMD_NONE, cc: 8'h00};
  endtask

  task lvl(input logic [1:0] e);
    @(negedge clk_sys);
    chk("level bits", e, {cc_out[nic_pkg::CC_HI_BIT], cc_out[nic_pkg::CC_LO_BIT]});
    chk("masked", e == nic_pkg::LVL3, level_masked);
  endtask

  task wait_n();
    int i;
    int n0;
    n0 = n_ack;
    i = 0;
    while (n_ack == n0 && i < 40) begin
      @(posedge clk_sys);
      i++;
    end
    if (i >= 40) begin
      err_total++;
      end_of_test();
    end
  endtask

  task want(input logic [3:0] v);
    wait_n();
    chk("served vector", v, last_sel.vec);
  endtask

  task quiet(input int n);
    int n0;
    n0 = n_ack;
    repeat (n) @(posedge clk_sys);
    chk("no service", n0, n_ack);
  endtask

  task raise(input logic [13:0] m);
    @(posedge clk_sys);
    periph_flag <= periph_flag | m;
    periph_en   <= periph_en | m;
  endtask

  // Flag drops at the same edge so the latch cannot be set again
  task pclr(input logic [13:0] m);
    @(posedge clk_sys);
    periph_flag <= periph_flag & ~m;
    periph_clr  <= m;
    @(posedge clk_sys);
    periph_clr  <= '0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_reset();
    logic [31:0] q;
    wait_n();
    chk("reset kind", nic_pkg::NIC_KIND_RESET, last_sel.kind);
    lvl(nic_pkg::LVL3);
    chk("cc reset", 8'hea, cc_out & 8'hef);
    bus(1'b0, nic_pkg::REG_FLAGS, 32'h0, q);
    chk("flags read", 32'hea, q & 32'hef);
    for (int b = 0; b < 4; b++) begin
      bus(1'b0, b[2:0], 32'h0, q);
      chk("bank reset", 32'hff, q);
    end
    bus(1'b0, 3'h7, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask

  task s_regs();
    logic [31:0] q;
    bus(1'b1, nic_pkg::REG_BANK0, 32'hcf, q);
    bus(1'b1, nic_pkg::REG_BANK0, 32'h64, q);
    bus(1'b0, nic_pkg::REG_BANK0, 32'h0, q);
    chk("bank0 keep", 32'h44, q);
    bus(1'b1, nic_pkg::REG_BANK3, 32'h00, q);
    bus(1'b0, nic_pkg::REG_BANK3, 32'h0, q);
    chk("bank3 top", 32'hf0, q);
    bus(1'b1, 3'h2, 32'h51, q);
    bus(1'b0, 3'h2, 32'h0, q);
    chk("bank2", 32'h51, q);
  endtask

  task s_instr();
    ins(nic_pkg::NIC_CMD_IRQ_EN, 8'h00);
    lvl(nic_pkg::LVL0);
    ins(nic_pkg::NIC_CMD_POPCC, 8'h00);
    lvl(nic_pkg::LVL2);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h08);
    lvl(nic_pkg::LVL1);
    ins(nic_pkg::NIC_CMD_IRQ_DIS, 8'h00);
    lvl(nic_pkg::LVL3);
    // Frozen clock enable: the enable instruction must not land
    @(posedge clk_sys);
    ce <= 1'b0;
    ins(nic_pkg::NIC_CMD_IRQ_EN, 8'h00);
    lvl(nic_pkg::LVL3);
    @(posedge clk_sys);
    ce <= 1'b1;
  endtask

  // Vec 9 at level 2; vec 8 and 11 at level 1; vec 12 flagged but disabled
  task s_prio();
    @(posedge clk_sys);
    periph_flag <= 14'h1b00;
    periph_en   <= 14'h0b00;
    quiet(8);
    ins(nic_pkg::NIC_CMD_IRQ_EN, 8'h00);
    want(4'h9);
    lvl(nic_pkg::LVL2);
    quiet(6);
    pclr(14'h0200);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
    want(4'h8);
    lvl(nic_pkg::LVL1);
    pclr(14'h0900);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
    quiet(8);
    periph_flag <= '0;
    periph_en   <= '0;
  endtask

  task s_trap();
    ins(nic_pkg::NIC_CMD_IRQ_DIS, 8'h00);
    ins(nic_pkg::NIC_CMD_TRAP, 8'h00);
    wait_n();
    chk("trap kind", nic_pkg::NIC_KIND_TRAP, last_sel.kind);
    lvl(nic_pkg::LVL3);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
  endtask

  task s_ext();
    logic [31:0] q;
    bus(1'b1, nic_pkg::REG_PINSEL, 32'h0002, q);
    ext_pins <= 16'h0001;
    quiet(8);
    ext_pins <= 16'h0003;
    want(4'h2);
    bus(1'b0, nic_pkg::REG_PEND, 32'h0, q);
    chk("pend cleared", 1'b0, q[2]);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
    quiet(8);
    ext_pins <= '0;
  endtask

  task s_wait();
    ins(nic_pkg::NIC_CMD_WAIT_IRQ, 8'h00);
    lvl(nic_pkg::LVL0);
    chk("asleep", 1'b1, cpu_sleep);
    raise(14'h0400);
    want(4'ha);
    chk("awake", 1'b0, cpu_sleep);
    pclr(14'h0400);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
  endtask

  // Vec 9 beats vec 13 on the level-2 tie normally, but only 13 may leave halt
  task s_halt();
    ins(nic_pkg::NIC_CMD_HALT, 8'h00);
    lvl(nic_pkg::LVL0);
    raise(14'h0200);
    quiet(8);
    chk("still halted", 1'b1, cpu_sleep);
    chk("no wake", 1'b0, cpu_wake);
    raise(14'h2000);
    want(4'hd);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
    want(4'h9);
    pclr(14'h2200);
    ins(nic_pkg::NIC_CMD_IRQ_RET, 8'h20);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    err_total     = 0;
    n_tests       = 0;
    rstn          = 1'b0;
    ce            = 1'b1;
    avs_address   = 3'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    ext_pins      = 16'h0;
    periph_flag   = 14'h0;
    periph_en     = 14'h0;
    periph_clr    = 14'h0;
    cpu_instr     = '{cmd: nic_pkg::NIC_CMD_NONE, cc: 8'h00};
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    s_reset();
    s_regs();
    s_instr();
    s_prio();
    s_trap();
    s_ext();
    s_wait();
    s_halt();
    end_of_test();
  end
endmodule

// ---- bench/nic_cpu_model.sv ----
`timescale 1ns/1ps
module nic_cpu_model #(
  parameter int DLY = 2
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire nic_pkg::nic_sel_t irq_sel,
  output logic                   irq_ack,
  output int                     n_ack,
  output nic_pkg::nic_sel_t      last_sel
);
  int wait_q;

  // Slow acknowledge stands in for finishing the instruction and stacking
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_ack  <= 1'b0;
      wait_q   <= 0;
      n_ack    <= 0;
      last_sel <= '0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      wait_q  <= 0;
      if (irq_sel.valid) begin
        n_ack    <= n_ack + 1;
        last_sel <= irq_sel;
      end
    end else if (irq_sel.valid) begin
      if (wait_q >= DLY) begin
        irq_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 1;
      end
    end else begin
      wait_q <= 0;
    end
  end
endmodule

// ---- design/nic_ctrl.sv ----
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module nic_ctrl #(
  parameter int NGRP  = 4,
  parameter int GPINS = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire logic [2:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [NGRP*GPINS-1:0] ext_pins,
  input  wire logic [13:0]           periph_flag,
  input  wire logic [13:0]           periph_en,
  input  wire logic [13:0]           periph_clr,
  input  wire nic_pkg::nic_instr_t   cpu_instr,
  input  wire logic                  irq_ack,
  output nic_pkg::nic_sel_t          irq_sel,
  output logic      [7:0]            cc_out,
  output logic                       level_masked,
  output logic                       cpu_sleep,
  output logic                       cpu_wake
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (nic_pkg::EXT_BASE + NGRP > nic_pkg::NVEC || NGRP < 1 || GPINS < 1 ||
      NGRP * GPINS > 32) begin : g_bad_cfg
    $error("nic_ctrl: pin grouping does not fit the vector table");
  end

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_HALT, ST_HALT_EXIT} nic_state_t;

  nic_state_t              state_q;
  logic [7:0]              cc_q;
  logic [7:0]              bank_q [nic_pkg::NBANK];
  logic [NGRP*GPINS-1:0]   pinsel_q;
  logic [NGRP*GPINS-1:0]   sync1_q;
  logic [NGRP*GPINS-1:0]   sync2_q;
  logic [NGRP-1:0]         grp_prev_q;
  logic [NGRP-1:0]         grp_now;
  logic [13:0]             ext_pend_q;
  logic [13:0]             per_pend_q;
  logic [13:0]             ext_set;
  logic [13:0]             ext_mask;
  logic [13:0]             per_set;
  logic [13:0]             pend;
  logic [13:0]             elig;
  logic                    reset_pend_q;
  logic                    trap_pend_q;
  logic                    rsp_q;
  logic [31:0]             rdata_q;
  logic [1:0]              cur_rank;
  logic [1:0]              best_r;
  nic_pkg::nic_sel_t       sel;
  nic_pkg::nic_sel_t       irq_q;
  logic                    wr_hit;
  logic                    rd_take;
  logic                    ack_mask;

  function automatic logic [1:0] vlev(input logic [7:0] b [nic_pkg::NBANK], input int v);
    vlev = b[v / 4][2 * (v % 4) +: 2];
  endfunction

  // ----------------------------------------
  // Avalon slave: one wait state per access
  // ----------------------------------------
  // Answer held back while frozen, else a write could be lost
  assign avs_waitrequest = (avs_read | avs_write) & ~(rsp_q & ce);
  assign wr_hit  = ce & avs_write & rsp_q;
  assign rd_take = ce & avs_read & ~rsp_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_q <= 1'b0;
    end else if (ce) begin
      rsp_q <= (avs_read | avs_write) & ~rsp_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (rd_take) begin
      rdata_q <= 32'h0;
      if (avs_address <= nic_pkg::REG_BANK3) begin
        rdata_q[7:0] <= bank_q[avs_address[1:0]];
      end else if (avs_address == nic_pkg::REG_FLAGS) begin
        rdata_q[7:0] <= cc_q;
      end else if (avs_address == nic_pkg::REG_PINSEL) begin
        rdata_q[NGRP*GPINS-1:0] <= pinsel_q;
      end else if (avs_address == nic_pkg::REG_PEND) begin
        rdata_q[13:0] <= pend;
      end
    end
  end

  // ----------------------------------------
  // Level banks
  // ----------------------------------------
  // Level-0 code is refused per field so a partial update is possible
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < nic_pkg::NBANK; b++) begin
        bank_q[b] <= nic_pkg::BANK_RESET;
      end
    end else if (wr_hit && avs_address <= nic_pkg::REG_BANK3) begin
      for (int f = 0; f < 4; f++) begin
        if (avs_writedata[2*f +: 2] != nic_pkg::LVL0) begin
          bank_q[avs_address[1:0]][2*f +: 2] <= avs_writedata[2*f +: 2];
        end
      end
      if (avs_address == nic_pkg::REG_BANK3) begin
        bank_q[3][7:4] <= nic_pkg::BANK3_FIXED;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinsel_q <= '0;
    end else if (wr_hit && avs_address == nic_pkg::REG_PINSEL) begin
      pinsel_q <= avs_writedata[NGRP*GPINS-1:0];
    end
  end

  // ----------------------------------------
  // External pins: sync, group OR, edge latch
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      grp_prev_q <= '0;
    end else if (ce) begin
      sync1_q    <= ext_pins;
      sync2_q    <= sync1_q;
      grp_prev_q <= grp_now;
    end
  end

  always_comb begin
    ext_set  = '0;
    ext_mask = '0;
    for (int g = 0; g < NGRP; g++) begin
      grp_now[g] = |(sync2_q[g*GPINS +: GPINS] & pinsel_q[g*GPINS +: GPINS]);
      ext_set[nic_pkg::EXT_BASE + g]  = grp_now[g] & ~grp_prev_q[g];
      ext_mask[nic_pkg::EXT_BASE + g] = 1'b1;
    end
  end

  assign ack_mask = ce & irq_ack & irq_q.valid & (irq_q.kind == nic_pkg::NIC_KIND_MASK);

  // New edge in the entry cycle survives: set wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_pend_q <= '0;
    end else if (ce) begin
      for (int v = 0; v < nic_pkg::NVEC; v++) begin
        if (ext_set[v]) begin
          ext_pend_q[v] <= 1'b1;
        end else if (ack_mask && irq_q.vec == 4'(v)) begin
          ext_pend_q[v] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Peripheral request latches
  // ----------------------------------------
  assign per_set = periph_flag & periph_en & ~ext_mask;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      per_pend_q <= '0;
    end else if (ce) begin
      per_pend_q <= per_set | (per_pend_q & ~periph_clr);
    end
  end

  assign pend = ext_pend_q | per_pend_q;

  // ----------------------------------------
  // Priority decision
  // ----------------------------------------
  assign cur_rank = nic_pkg::nic_rank({cc_q[nic_pkg::CC_HI_BIT], cc_q[nic_pkg::CC_LO_BIT]});

  always_comb begin
    sel      = '0;
    sel.kind = nic_pkg::NIC_KIND_MASK;
    best_r   = 2'h0;
    elig     = '0;
    for (int v = 0; v < nic_pkg::NVEC; v++) begin
      elig[v] = pend[v] && (nic_pkg::nic_rank(vlev(bank_q, v)) > cur_rank) &&
                (state_q != ST_HALT_EXIT || nic_pkg::HALT_CAP[v]);
      // Strict compare keeps the lower vector on a tie
      if (elig[v] && (!sel.valid || nic_pkg::nic_rank(vlev(bank_q, v)) > best_r)) begin
        sel.valid = 1'b1;
        sel.vec   = 4'(v);
        best_r    = nic_pkg::nic_rank(vlev(bank_q, v));
      end
    end
    if (reset_pend_q) begin
      sel.valid = 1'b1;
      sel.kind  = nic_pkg::NIC_KIND_RESET;
      sel.vec   = 4'h0;
    end else if (trap_pend_q) begin
      sel.valid = 1'b1;
      sel.kind  = nic_pkg::NIC_KIND_TRAP;
      sel.vec   = 4'h0;
    end
    if (state_q == ST_HALT || state_q == ST_WAIT) begin
      sel.valid = 1'b0;
    end
  end

  // Request withdrawn on the ack edge so it is never taken twice
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_q <= '0;
    end else if (ce) begin
      irq_q <= sel;
      if (irq_ack) begin
        irq_q.valid <= 1'b0;
      end
    end
  end

  assign irq_sel = irq_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reset_pend_q <= 1'b1;
      trap_pend_q  <= 1'b0;
    end else if (ce) begin
      if (irq_ack && irq_q.valid && irq_q.kind == nic_pkg::NIC_KIND_RESET) begin
        reset_pend_q <= 1'b0;
      end
      if (cpu_instr.cmd == nic_pkg::NIC_CMD_TRAP) begin
        trap_pend_q <= 1'b1;
      end else if (irq_ack && irq_q.valid && irq_q.kind == nic_pkg::NIC_KIND_TRAP) begin
        trap_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Condition flags
  // ----------------------------------------
  // Bank level is loaded only on entry; a bank rewrite mid-routine waits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cc_q <= nic_pkg::CC_RESET;
    end else if (ce) begin
      if (irq_ack && irq_q.valid) begin
        if (irq_q.kind == nic_pkg::NIC_KIND_MASK) begin
          {cc_q[nic_pkg::CC_HI_BIT], cc_q[nic_pkg::CC_LO_BIT]} <=
            vlev(bank_q, int'(irq_q.vec));
        end else begin
          cc_q[nic_pkg::CC_HI_BIT] <= 1'b1;
          cc_q[nic_pkg::CC_LO_BIT] <= 1'b1;
        end
      end else begin
        case (cpu_instr.cmd)
          nic_pkg::NIC_CMD_IRQ_EN, nic_pkg::NIC_CMD_HALT, nic_pkg::NIC_CMD_WAIT_IRQ: begin
            {cc_q[nic_pkg::CC_HI_BIT], cc_q[nic_pkg::CC_LO_BIT]} <= nic_pkg::LVL0;
          end
          nic_pkg::NIC_CMD_IRQ_DIS, nic_pkg::NIC_CMD_TRAP: begin
            {cc_q[nic_pkg::CC_HI_BIT], cc_q[nic_pkg::CC_LO_BIT]} <= nic_pkg::LVL3;
          end
          nic_pkg::NIC_CMD_IRQ_RET, nic_pkg::NIC_CMD_POPCC: begin
            cc_q <= cpu_instr.cc;
          end
          default: begin
            cc_q <= cc_q;
          end
        endcase
      end
    end
  end

  assign cc_out       = cc_q;
  assign level_masked = cur_rank == nic_pkg::nic_rank(nic_pkg::LVL3);

  // ----------------------------------------
  // Low-power state
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_RUN;
    end else if (ce) begin
      case (state_q)
        ST_RUN: begin
          if (cpu_instr.cmd == nic_pkg::NIC_CMD_HALT) begin
            state_q <= ST_HALT;
          end else if (cpu_instr.cmd == nic_pkg::NIC_CMD_WAIT_IRQ) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if ((|pend) || trap_pend_q) begin
            state_q <= ST_RUN;
          end
        end
        ST_HALT: begin
          if ((|(pend & nic_pkg::HALT_CAP[13:0])) || trap_pend_q) begin
            state_q <= ST_HALT_EXIT;
          end
        end
        ST_HALT_EXIT: begin
          if (irq_ack && irq_q.valid) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  assign cpu_sleep = (state_q == ST_WAIT) || (state_q == ST_HALT);
  assign cpu_wake  = (state_q == ST_WAIT && ((|pend) || trap_pend_q)) ||
                     (state_q == ST_HALT &&
                      ((|(pend & nic_pkg::HALT_CAP[13:0])) || trap_pend_q));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [1:0]              ack_lvl;
  logic [1:0]              win_r;
  logic                    win_beaten;
  assign ack_lvl = vlev(bank_q, int'(irq_q.vec));
  assign win_r   = nic_pkg::nic_rank(vlev(bank_q, int'(sel.vec)));
  always_comb begin
    win_beaten = 1'b0;
    for (int v = 0; v < nic_pkg::NVEC; v++) begin
      if (elig[v] && (nic_pkg::nic_rank(vlev(bank_q, v)) > win_r ||
          (nic_pkg::nic_rank(vlev(bank_q, v)) == win_r && 4'(v) < sel.vec))) begin
        win_beaten = 1'b1;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence nmi_entry_s;
    ce && irq_ack && irq_q.valid && irq_q.kind != nic_pkg::NIC_KIND_MASK;
  endsequence

  sequence mask_entry_s;
    ce && irq_ack && irq_q.valid && irq_q.kind == nic_pkg::NIC_KIND_MASK;
  endsequence

  nmi_level3_a: assert property (nmi_entry_s |=> level_masked)
    else $error("nmi entry did not force level 3");
  entry_load_a: assert property (mask_entry_s |=>
      {cc_q[nic_pkg::CC_HI_BIT], cc_q[nic_pkg::CC_LO_BIT]} == $past(ack_lvl))
    else $error("entry level not loaded from bank");
  strict_above_a: assert property (sel.valid && sel.kind == nic_pkg::NIC_KIND_MASK |->
      nic_pkg::nic_rank(vlev(bank_q, int'(sel.vec))) > cur_rank)
    else $error("maskable picked at or below current level");
  best_pick_a: assert property (sel.valid && sel.kind == nic_pkg::NIC_KIND_MASK |->
      elig[sel.vec] && !win_beaten && best_r == win_r)
    else $error("winner not highest level");
  halt_first_a: assert property (state_q == ST_HALT_EXIT && sel.valid &&
      sel.kind == nic_pkg::NIC_KIND_MASK |-> nic_pkg::HALT_CAP[sel.vec])
    else $error("non halt-capable source served first");
  wait_wake_a: assert property (ce && state_q == ST_WAIT && (|pend) |=>
      state_q == ST_RUN)
    else $error("pending source did not end wait");
  edge_clear_a: assert property ((mask_entry_s and
      (ext_mask[irq_q.vec] && !ext_set[irq_q.vec])) |=> !ext_pend_q[$past(irq_q.vec)])
    else $error("edge latch not cleared on entry");
  periph_drop_a: assert property (ce && (|(periph_clr & ~per_set)) |=>
      (per_pend_q & $past(periph_clr) & ~$past(per_set)) == '0)
    else $error("cleared peripheral request survived");
  level0_keep_a: assert property (wr_hit && avs_address == nic_pkg::REG_BANK0 &&
      avs_writedata[5:4] == nic_pkg::LVL0 |=> $stable(bank_q[0][5:4]))
    else $error("level-0 write changed a field");
  enable_instr_a: assert property (ce && !irq_ack &&
      cpu_instr.cmd == nic_pkg::NIC_CMD_IRQ_EN |=> !level_masked ##0 cur_rank == 2'h0)
    else $error("enable instruction did not load level 0");

endmodule

// ---- include/nic_pkg.sv ----
package nic_pkg;
  localparam int          NVEC        = 14;
  localparam int          NBANK       = 4;
  localparam logic [1:0]  LVL0        = 2'h2;
  localparam logic [1:0]  LVL1        = 2'h1;
  localparam logic [1:0]  LVL2        = 2'h0;
  localparam logic [1:0]  LVL3        = 2'h3;
  localparam int          CC_HI_BIT   = 5;
  localparam int          CC_LO_BIT   = 3;
  localparam logic [7:0]  CC_RESET    = 8'hea;
  localparam logic [7:0]  BANK_RESET  = 8'hff;
  localparam logic [3:0]  BANK3_FIXED = 4'hf;
  localparam logic [2:0]  REG_BANK0   = 3'h0;
  localparam logic [2:0]  REG_BANK3   = 3'h3;
  localparam logic [2:0]  REG_FLAGS   = 3'h4;
  localparam logic [2:0]  REG_PINSEL  = 3'h5;
  localparam logic [2:0]  REG_PEND    = 3'h6;
  localparam logic [15:0] HALT_CAP    = 16'h20be;
  localparam int          EXT_BASE    = 2;

  typedef enum logic [2:0] {
    NIC_CMD_NONE, NIC_CMD_IRQ_EN, NIC_CMD_IRQ_DIS, NIC_CMD_HALT,
    NIC_CMD_WAIT_IRQ, NIC_CMD_IRQ_RET, NIC_CMD_POPCC, NIC_CMD_TRAP
  } nic_cmd_t;

  typedef enum logic [1:0] {
    NIC_KIND_RESET, NIC_KIND_TRAP, NIC_KIND_MASK
  } nic_kind_t;

  typedef struct packed {
    logic      valid;
    nic_kind_t kind;
    logic [3:0] vec;
  } nic_sel_t;

  typedef struct packed {
    nic_cmd_t   cmd;
    logic [7:0] cc;
  } nic_instr_t;

  // Level code to rank: 0 lowest, 3 highest
  function automatic logic [1:0] nic_rank(input logic [1:0] code);
    case (code)
      LVL0:    nic_rank = 2'h0;
      LVL1:    nic_rank = 2'h1;
      LVL2:    nic_rank = 2'h2;
      default: nic_rank = 2'h3;
    endcase
  endfunction
endpackage
